// ---- pkg/dolc_pkg.sv ----
package dolc_pkg;

  // ---------------------------------------------------------------
  // register offsets, decoded as the full bus byte address
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_GEN_CFG = 8'h02;
  localparam logic [7:0] REG_PORT_LOCK_FLAG = 8'h4D;
  localparam logic [7:0] REG_PORT_CFG = 8'h6D;
  localparam logic [7:0] REG_IND_PAGE = 8'hB0;
  localparam logic [7:0] REG_IND_ADDR = 8'hB1;
  localparam logic [7:0] REG_IND_DATA = 8'hB2;
  localparam logic [7:0] REG_IRQ_STS = 8'hC0;
  localparam logic [7:0] REG_IRQ_MASK = 8'hC1;
  localparam logic [7:0] REG_CTRL = 8'hC2;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int GEN_OEN_OVR = 0;
  localparam int GEN_OEN_VAL = 1;
  localparam int GEN_OSS_OVR = 2;
  localparam int GEN_OSS_VAL = 3;
  localparam int PCFG_COAX = 2;
  localparam int CTRL_PSEL_OVR = 0;
  localparam int CTRL_PSEL_VAL = 1;
  localparam int CTRL_GPIO_LOCK = 2;
  localparam int IRQ_LOCK_UP = 0;
  localparam int IRQ_LOCK_LOST = 1;
  localparam int IRQ_EQ_RESTART = 2;

  // ---------------------------------------------------------------
  // reset values and indirect space
  // ---------------------------------------------------------------
  localparam logic [7:0] GEN_CFG_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PAGE_MON = 8'h14;
  localparam logic [7:0] PAGE_PORT = 8'h18;
  localparam logic [7:0] MON_EN_ADDR = 8'h00;
  localparam logic [7:0] MON_EN_BIT = 8'h80;
  localparam logic [7:0] MON_MUX_ADDR = 8'h02;
  localparam logic [7:0] MON_MUX_P1 = 8'hA0;
  localparam logic [7:0] IND_RST = 8'h00;

  // ---------------------------------------------------------------
  // equalizer restart timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int EQ_RST_NS = 400;
  localparam int EQ_RST_CYC = (EQ_RST_NS * CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DOLC_RSV = 2'b00,
    DOLC_WIDE_LF = 2'b01,
    DOLC_WIDE_HF = 2'b10,
    DOLC_NARROW = 2'b11
  } dolc_mode_t;

  // link clock ratio to pixel clock: num/den
  typedef struct packed {
    logic [1:0] num;
    logic [1:0] den;
  } dolc_ratio_t;

  typedef struct packed {
    logic [11:0] data;
    logic hsync;
    logic vsync;
  } dolc_pix_t;

  typedef struct packed {
    logic active;
    logic pclk_present;
  } dolc_link_t;

  typedef enum logic [1:0] {
    DOLC_EQ_ACQ = 2'b00,
    DOLC_EQ_LOCK = 2'b01,
    DOLC_EQ_RST = 2'b11
  } dolc_eq_t;

endpackage

// ---- src/dolc_top.sv ----
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
module dolc_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins and strap
  input wire logic [2:0] mode_strap_i,
  input wire logic power_down_n_i,
  input wire logic output_enable_in_i,
  input wire logic output_state_select_i,
  input wire logic port_sel_i,
  // serial link front end, one per port
  input wire dolc_pkg::dolc_link_t [1:0] link_i,
  input wire dolc_pkg::dolc_pix_t [1:0] rx_pix_i,
  // parallel video port, value and enable
  output dolc_pkg::dolc_pix_t pix_o,
  output logic pix_oe_o,
  output logic pclk_o,
  output logic pclk_oe_o,
  output logic lock_o,
  output logic lock_oe_o,
  output logic pass_o,
  output logic pass_oe_o,
  // side outputs
  output logic gpio_lock_o,
  output logic [1:0] remote_ok_o,
  output logic [1:0] eq_reset_o,
  output logic mon_enable_o,
  output logic mon_port_o,
  output dolc_pkg::dolc_ratio_t ratio_o,
  output logic irq_o
);
  import dolc_pkg::*;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] byte_wr(input logic [7:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
    byte_wr = s[0] ? d[7:0] : old;
  endfunction

  // lock rule by mode: high-freq needs pixel clock at serializer
  function automatic logic lock_of(input dolc_mode_t m,
                                   input dolc_link_t l);
    if (m == DOLC_WIDE_HF)
      lock_of = l.active & l.pclk_present;
    else
      lock_of = l.active;
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] gen_cfg_q;
  logic [7:0] ctrl_q;
  logic [2:0] port_cfg_q;
  logic [7:0] page_q;
  logic [7:0] iaddr_q;
  logic [7:0] idata_q;
  logic [2:0] irq_sts_q;
  logic [2:0] irq_mask_q;
  logic mon_en_q;
  logic mon_port_q;
  logic [7:0] mon_mux_q;
  logic [7:0] port_reg_q;
  logic strap_done_q;
  logic [1:0] lock_flag_q;
  logic [1:0] lock_flag_d;
  logic pin_lock_q;
  dolc_eq_t eq_state_q [2];
  logic [3:0] eq_cnt_q [2];

  logic wr_en;
  logic rd_en;
  logic [7:0] idx;
  logic output_enable_in;
  logic oss;
  logic psel;
  logic pin_lock_d;
  logic [2:0] irq_ev;
  dolc_mode_t mode;

  assign idx = wb_adr_i; // offsets never alias: full byte compare
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign mode = dolc_mode_t'(port_cfg_q[1:0]);

  // override muxes for pins
  assign output_enable_in = gen_cfg_q[GEN_OEN_OVR] ? gen_cfg_q[GEN_OEN_VAL]
             : output_enable_in_i;
  assign oss = gen_cfg_q[GEN_OSS_OVR] ? gen_cfg_q[GEN_OSS_VAL]
             : output_state_select_i;
  assign psel = ctrl_q[CTRL_PSEL_OVR] ? ctrl_q[CTRL_PSEL_VAL]
              : port_sel_i;

  // ---------------------------------------------------------------
  // wishbone ack: one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  // read mux, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (rd_en)
    begin
      case (idx)
        REG_GEN_CFG: wb_dat_o <= {24'h0, gen_cfg_q};
        REG_PORT_LOCK_FLAG: wb_dat_o <= {31'h0, lock_flag_q[psel]};
        REG_PORT_CFG: wb_dat_o <= {29'h0, port_cfg_q};
        REG_IND_PAGE: wb_dat_o <= {24'h0, page_q};
        REG_IND_ADDR: wb_dat_o <= {24'h0, iaddr_q};
        REG_IND_DATA: wb_dat_o <= {24'h0, idata_q};
        REG_IRQ_STS: wb_dat_o <= {29'h0, irq_sts_q};
        REG_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask_q};
        REG_CTRL: wb_dat_o <= {24'h0, ctrl_q};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // plain control registers; a shortened index would alias them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gen_cfg_q <= GEN_CFG_RST;
      ctrl_q <= CTRL_RST;
      irq_mask_q <= 3'h0;
    end
    else if (wr_en)
    begin
      if (idx == REG_GEN_CFG)
        gen_cfg_q <= byte_wr(gen_cfg_q, wb_dat_i, wb_sel_i);
      if (idx == REG_CTRL)
        ctrl_q <= byte_wr(ctrl_q, wb_dat_i, wb_sel_i);
      if (idx == REG_IRQ_MASK && wb_sel_i[0])
        irq_mask_q <= wb_dat_i[2:0];
    end
  end

  // strap capture after reset release, software may override
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strap_done_q <= 1'b0;
      port_cfg_q <= 3'h0;
    end
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'b1;
      port_cfg_q <= mode_strap_i;
    end
    else if (wr_en && idx == REG_PORT_CFG && wb_sel_i[0])
      port_cfg_q <= wb_dat_i[2:0];
  end

  // ---------------------------------------------------------------
  // indirect access: page, address, data port
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      page_q <= IND_RST;
      iaddr_q <= IND_RST;
      idata_q <= IND_RST;
      mon_en_q <= 1'b0;
      mon_mux_q <= IND_RST;
      port_reg_q <= IND_RST;
    end
    else if (wr_en && wb_sel_i[0])
    begin
      if (idx == REG_IND_PAGE)
        page_q <= wb_dat_i[7:0];
      if (idx == REG_IND_ADDR)
        iaddr_q <= wb_dat_i[7:0];
      if (idx == REG_IND_DATA)
      begin
        idata_q <= wb_dat_i[7:0];
        // data write lands at the addressed location; on the port page any address writes port_reg_q
        if (page_q == PAGE_MON && iaddr_q == MON_EN_ADDR)
          mon_en_q <= (wb_dat_i[7:0] & MON_EN_BIT) != 8'h00;
        if (page_q == PAGE_MON && iaddr_q == MON_MUX_ADDR)
          mon_mux_q <= wb_dat_i[7:0];
        if (page_q == PAGE_PORT)
          port_reg_q <= wb_dat_i[7:0];
      end
    end
  end

  // monitor outputs follow indirect state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mon_enable_o <= 1'b0;
      mon_port_o <= 1'b0;
      mon_port_q <= 1'b0;
    end
    else
    begin
      mon_port_q <= mon_mux_q == MON_MUX_P1;
      mon_enable_o <= mon_en_q;
      mon_port_o <= mon_port_q;
    end
  end

  // ---------------------------------------------------------------
  // lock generation
  // ---------------------------------------------------------------
  always_comb
  begin
    lock_flag_d = {link_i[1].active, link_i[0].active};
    pin_lock_d = lock_of(mode, link_i[psel]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lock_flag_q <= 2'b00;
      pin_lock_q <= 1'b0;
      gpio_lock_o <= 1'b0;
      remote_ok_o <= 2'b00;
    end
    else
    begin
      lock_flag_q <= lock_flag_d;
      pin_lock_q <= pin_lock_d;
      gpio_lock_o <= ctrl_q[CTRL_GPIO_LOCK] & lock_flag_d[psel];
      remote_ok_o <= lock_flag_d;
    end
  end

  // ---------------------------------------------------------------
  // adaptive equalizer restart per port
  // ---------------------------------------------------------------
  for (genvar p = 0; p < 2; p++)
  begin : g_eq
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        eq_state_q[p] <= DOLC_EQ_ACQ;
        eq_cnt_q[p] <= 4'h0;
      end
      else
      begin
        case (eq_state_q[p])
          DOLC_EQ_ACQ:
            if (lock_flag_d[p])
              eq_state_q[p] <= DOLC_EQ_LOCK;
          DOLC_EQ_LOCK:
            if (!lock_flag_d[p])
            begin
              eq_state_q[p] <= DOLC_EQ_RST;
              eq_cnt_q[p] <= 4'(EQ_RST_CYC);
            end
          DOLC_EQ_RST:
            if (eq_cnt_q[p] <= 4'h1)
              eq_state_q[p] <= DOLC_EQ_ACQ;
            else
              eq_cnt_q[p] <= eq_cnt_q[p] - 4'h1;
          default: eq_state_q[p] <= DOLC_EQ_ACQ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      eq_reset_o <= 2'b00;
    else
      eq_reset_o <= {eq_state_q[1] == DOLC_EQ_RST,
                     eq_state_q[0] == DOLC_EQ_RST};
  end

  // link clock ratio by mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ratio_o <= '0;
    else
    begin
      case (mode)
        DOLC_NARROW: ratio_o <= '{num: 2'd1, den: 2'd2};
        DOLC_WIDE_HF: ratio_o <= '{num: 2'd2, den: 2'd3};
        DOLC_WIDE_LF: ratio_o <= '{num: 2'd1, den: 2'd1};
        default: ratio_o <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output state table, evaluated every clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pix_o <= '0;
      pix_oe_o <= 1'b0;
      pclk_o <= 1'b0;
      pclk_oe_o <= 1'b0;
      lock_o <= 1'b0;
      lock_oe_o <= 1'b0;
      pass_o <= 1'b0;
      pass_oe_o <= 1'b0;
    end
    else if (!power_down_n_i)
    begin
      pix_oe_o <= 1'b0;
      pclk_oe_o <= 1'b0;
      lock_oe_o <= 1'b0;
      pass_oe_o <= 1'b0;
    end
    else if (!output_enable_in)
    begin
      pix_o <= '0;
      pclk_o <= 1'b0;
      lock_o <= 1'b0;
      pass_o <= 1'b0;
      pix_oe_o <= ~oss;
      pclk_oe_o <= ~oss;
      lock_oe_o <= ~oss;
      pass_oe_o <= ~oss;
    end
    else
    begin
      // all enables driven in any enabled state
      pix_oe_o <= 1'b1;
      pclk_oe_o <= 1'b1;
      lock_oe_o <= 1'b1;
      pass_oe_o <= 1'b1;
      lock_o <= pin_lock_d;
      if (pin_lock_d && oss)
      begin
        pix_o <= rx_pix_i[psel];
        pclk_o <= ~pclk_o;
        pass_o <= 1'b1;
      end
      else
      begin
        pix_o <= '0;
        pclk_o <= 1'b0;
        if (!oss)
          pass_o <= 1'b0; // static+oss=1 keeps pass
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupts: set wins over write-one clear
  // ---------------------------------------------------------------
  assign irq_ev[IRQ_LOCK_UP] = pin_lock_d & ~pin_lock_q;
  assign irq_ev[IRQ_LOCK_LOST] = ~pin_lock_d & pin_lock_q;
  assign irq_ev[IRQ_EQ_RESTART] = |(lock_flag_q & ~lock_flag_d);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_sts_q <= 3'h0;
    else if (wr_en && idx == REG_IRQ_STS && wb_sel_i[0])
      irq_sts_q <= (irq_sts_q & ~wb_dat_i[2:0]) | irq_ev;
    else
      irq_sts_q <= irq_sts_q | irq_ev;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_sts_q & irq_mask_q);
  end

endmodule

// ---- dv/dolc_ser_model.sv ----
`timescale 1ns/1ps
module dolc_ser_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench control
  input wire logic run_i,
  input wire logic osc_only_i,
  // link toward the receiver
  output dolc_pkg::dolc_link_t link_o,
  output dolc_pkg::dolc_pix_t pix_o
);
  import dolc_pkg::*;
  // link state; own oscillator means no pixel clock
  always_ff @(posedge clk_i)
    link_o <= '{active: run_i,
                pclk_present: run_i && !osc_only_i};
  // stream counts when running, inverts every clock when idle
  always_ff @(posedge clk_i)
    if (rst_i)
      pix_o <= '0;
    else
      pix_o <= run_i ? pix_o + 14'h0001 : ~pix_o;
endmodule

// ---- dv/dolc_asserts.sv ----
`timescale 1ns/1ps
module dolc_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // pins and link
  input wire logic power_down_n_i,
  input wire dolc_pkg::dolc_link_t [1:0] link_i,
  // outputs
  input wire logic lock_o,
  input wire logic lock_oe_o,
  input wire logic pix_oe_o,
  input wire logic pclk_oe_o,
  input wire logic pass_oe_o,
  input wire logic gpio_lock_o,
  input wire logic [1:0] remote_ok_o,
  input wire logic [1:0] eq_reset_o,
  input wire dolc_pkg::dolc_ratio_t ratio_o
);
  import dolc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("ack missing");
  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("ack too long");
  property p_pd_float;
    !power_down_n_i |=> !(lock_oe_o | pix_oe_o | pclk_oe_o | pass_oe_o);
  endproperty
  a_pd_float: assert property (p_pd_float)
    else $error("driving in power-down");
  property p_static_low;
    power_down_n_i && !link_i[0].active && !link_i[1].active
      |=> !(lock_o && lock_oe_o);
  endproperty
  a_static_low: assert property (p_static_low)
    else $error("lock with static input");
  property p_lock_link;
    lock_o && lock_oe_o |-> $past(link_i[0].active || link_i[1].active);
  endproperty
  a_lock_link: assert property (p_lock_link)
    else $error("lock without link");
  property p_flag_up;
    $rose(link_i[0].active) |-> ##[1:40] remote_ok_o[0];
  endproperty
  a_flag_up: assert property (p_flag_up)
    else $error("lock flag late");
  property p_remote_gate;
    !link_i[1].active |=> !remote_ok_o[1];
  endproperty
  a_remote_gate: assert property (p_remote_gate)
    else $error("remote access without lock");
  property p_eq_restart;
    $fell(remote_ok_o[0]) |-> ##[0:2] eq_reset_o[0];
  endproperty
  a_eq_restart: assert property (p_eq_restart)
    else $error("equalizer not restarted");
  property p_ratio;
    ratio_o inside {4'h0, 4'h5, 4'h6, 4'hB};
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("bad clock ratio");
  property p_gpio;
    gpio_lock_o |-> remote_ok_o != 2'h0 || $past(remote_ok_o) != 2'h0;
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("gpio lock without flag");
endmodule

bind dolc_top dolc_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .power_down_n_i(power_down_n_i), .link_i(link_i), .lock_o(lock_o),
  .lock_oe_o(lock_oe_o), .pix_oe_o(pix_oe_o), .pclk_oe_o(pclk_oe_o),
  .pass_oe_o(pass_oe_o), .gpio_lock_o(gpio_lock_o),
  .remote_ok_o(remote_ok_o), .eq_reset_o(eq_reset_o), .ratio_o(ratio_o)
);

// ---- dv/dolc_top_tb.sv ----
`timescale 1ns/1ps
module dolc_top_tb;
  import dolc_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic pd = 1, output_enable_in = 1, oss = 1, psel = 0, pclk, pass, gpio, irq;
  logic lock, lock_oe, pix_oe, pclk_oe, pass_oe, mon_en, mon_p, ex_oe;
  logic pc;
  logic [7:0] adr = '0, rd;
  logic [2:0] strap = 3'h1;
  logic [31:0] dat = '0, rdat;
  logic [1:0] run = '0, osc = '0, rok, eqr;
  dolc_link_t [1:0] link;
  dolc_pix_t [1:0] rx;
  dolc_pix_t pix, pprev;
  dolc_ratio_t ratio;
  int err_total = 0, total_checks = 0;
  logic [2:0] st [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
  logic [3:0] rtab [4] = '{4'h0, 4'h5, 4'hB, 4'h6};
  logic [15:0] seq [14] = '{16'hB014, 16'hB100, 16'hB280, 16'hB102,
    16'hB2A0, 16'hB103, 16'hB228, 16'hB104, 16'hB228, 16'hB018,
    16'hB10F, 16'hB201, 16'hB110, 16'hB202};
  // clock and selected port history
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) pprev <= rx[psel];
  // ---------------------------------------------------------------
  // design and far side
  // ---------------------------------------------------------------
  dolc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .mode_strap_i(strap), .power_down_n_i(pd),
    .output_enable_in_i(output_enable_in), .output_state_select_i(oss),
    .port_sel_i(psel), .link_i(link), .rx_pix_i(rx), .pix_o(pix),
    .pix_oe_o(pix_oe), .pclk_o(pclk), .pclk_oe_o(pclk_oe),
    .lock_o(lock), .lock_oe_o(lock_oe), .pass_o(pass),
    .pass_oe_o(pass_oe), .gpio_lock_o(gpio), .remote_ok_o(rok),
    .eq_reset_o(eqr), .mon_enable_o(mon_en), .mon_port_o(mon_p),
    .ratio_o(ratio), .irq_o(irq));
  for (genvar p = 0; p < 2; p++)
  begin : g_ser
    dolc_ser_model u_ser (.clk_i(clk_i), .rst_i(rst_i), .run_i(run[p]),
      .osc_only_i(osc[p]), .link_o(link[p]), .pix_o(rx[p]));
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      err_total++;
    end
  endtask
  task automatic wb(input logic [7:0] r, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= r;
    dat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk_i);
    end
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20)
    begin
      $display("ERROR t=%0t ack timeout got=%h exp=%h", $time, ack, 1'b1);
      err_total++;
      results();
    end
  endtask
  task automatic rchk(input logic [7:0] r, input logic [7:0] e);
    wb(r, 1'b0, 8'h00);
    chk(rd, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    foreach (st[i])
    begin
      strap <= st[i];
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rchk(REG_PORT_CFG, {5'h00, st[i]});
    end
    for (int m = 0; m < 4; m++)
    begin
      wb(REG_PORT_CFG, 1'b1, 8'(m));
      rchk(REG_PORT_CFG, 8'(m));
      tick(2);
      chk(ratio, rtab[m]);
    end
    wb(REG_PORT_CFG, 1'b1, 8'h01);
    $display("strap and mode test done");
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_i);
      {run[0], pd, output_enable_in, oss} <= 4'(i);
      tick(40);
      ex_oe = pd && (output_enable_in || !oss);
      chk({lock_oe, pix_oe, pclk_oe, pass_oe}, {4{ex_oe}});
      chk(lock && lock_oe, pd && output_enable_in && run[0]);
      if (ex_oe && !(run[0] && output_enable_in && oss))
        chk({pix, pclk}, '0);
      if (ex_oe && !oss)
        chk(pass, 1'b0);
      if (run[0] && pd && output_enable_in && oss)
      begin
        chk(pix, pprev);
        chk(pass, 1'b1);
        pc = pclk;
        tick(1);
        chk(pclk, !pc);
      end
    end
    @(posedge clk_i);
    run[0] <= 1'b0;
    tick(40);
    chk({lock, pass}, 2'h1);
    @(posedge clk_i);
    run[0] <= 1'b1;
    $display("output state test done");
    @(posedge clk_i);
    output_enable_in <= 1'b0;
    wb(REG_GEN_CFG, 1'b1, 8'h07);
    wb(REG_CTRL, 1'b1, 8'h04);
    tick(3);
    chk({lock_oe, lock, pass_oe, pass, gpio}, 5'h1D);
    rchk(REG_GEN_CFG, 8'h07);
    wb(REG_GEN_CFG, 1'b1, 8'h00);
    output_enable_in <= 1'b1;
    osc[0] <= 1'b1;
    wb(REG_PORT_CFG, 1'b1, 8'h02);
    tick(40);
    chk(lock, 1'b0);
    rchk(REG_PORT_LOCK_FLAG, 8'h01);
    for (int m = 1; m < 4; m += 2)
    begin
      wb(REG_PORT_CFG, 1'b1, 8'(m));
      tick(40);
      chk(lock, 1'b1);
    end
    @(posedge clk_i);
    osc[0] <= 1'b0;
    psel <= 1'b1;
    tick(40);
    chk({rok, lock}, 3'h2);
    @(posedge clk_i);
    run[1] <= 1'b1;
    tick(40);
    chk({rok, lock}, 3'h7);
    chk(pix, pprev);
    @(posedge clk_i);
    psel <= 1'b0;
    wb(REG_IRQ_STS, 1'b1, 8'hFF);
    wb(REG_IRQ_MASK, 1'b1, 8'h04);
    run[0] <= 1'b0;
    tick(4);
    chk({eqr[0], irq}, 2'h3);
    rchk(REG_IRQ_STS, 8'h06);
    wb(REG_IRQ_MASK, 1'b1, 8'h00);
    tick(2);
    chk(irq, 1'b0);
    wb(REG_IRQ_MASK, 1'b1, 8'h04);
    wb(REG_IRQ_STS, 1'b1, 8'h06);
    tick(2);
    chk(irq, 1'b0);
    $display("lock and irq test done");
    for (int p = 0; p < 2; p++)
    begin
      foreach (seq[i])
        wb(seq[i][15:8], 1'b1, (i == 4 && p == 0) ? 8'h20 : seq[i][7:0]);
      tick(3);
      chk({mon_en, mon_p}, {1'b1, 1'(p)});
    end
    rchk(REG_IND_PAGE, 8'h18);
    wb(8'h04, 1'b1, 8'hFF);
    rchk(8'h04, 8'h00);
    $display("indirect test done");
    results();
  end
endmodule
